// file: dv/ipsel_pin_partner.sv
// partner: external logic on the microphone clock pin
`timescale 1ns/100ps

module ipsel_pin_partner (
  input  wire logic clk_sys,
  input  wire logic pin_o,
  input  wire logic pin_oe_n,
  input  wire logic ext_en,
  input  wire logic ext_val,
  output logic      pin_lvl
);
  logic wander_q = 1'b0;

  // no pull on this wire: a released pin wanders instead of holding
  always_ff @(posedge clk_sys) begin
    wander_q <= ~wander_q;
  end

  assign pin_lvl = !pin_oe_n ? pin_o : (ext_en ? ext_val : wander_q);
endmodule

// file: dv/ipsel_top_tb_top.sv
// testbench: interrupt pulses and pin function select
`timescale 1ns/100ps

module ipsel_top_tb_top
  import ipsel_pkg::*;
;
  localparam int PUL = 4;
  localparam int PER = 10;
  logic clk_sys, srst, reg_wr, reg_rd, ext_en, ext_val, pin_lvl, pin_o, pin_oe_n, pin_ie;
  logic irq_a, irq_b, sec_pin_in, general_input, div_clk, bclk, wclk, mod_clk;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  ipsel_evt_t evt, evt_pending;
  int seed = 88713;
  int fails = 0;
  int check_count = 0;

  ipsel_top #(.PULSE_CYC(PUL), .PERIOD_CYC(PER)) u_dut (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .evt(evt), .evt_pending(evt_pending),
    .divided_clock_out(div_clk), .sec_bclk_out(bclk), .sec_wclk_out(wclk), .modulator_clock(mod_clk),
    .mic_clock_pin_i(pin_lvl), .mic_clock_pin_o(pin_o), .mic_clock_pin_oe_n(pin_oe_n),
    .mic_clock_pin_ie(pin_ie), .irq_out_a(irq_a), .irq_out_b(irq_b), .sec_pin_in(sec_pin_in),
    .general_input(general_input));

  ipsel_pin_partner u_far (.clk_sys(clk_sys), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
    .ext_val(ext_val), .pin_lvl(pin_lvl));

  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask

  task automatic fire(input logic [2:0] v);
    @(posedge clk_sys);
    evt <= ipsel_evt_t'(v);
    @(posedge clk_sys);
    evt <= '0;
    @(negedge clk_sys);
  endtask

  // high samples of both outputs over n cycles
  task automatic count(input int n, output int na, output int nb);
    na = 0;
    nb = 0;
    repeat (n) begin
      na += int'(irq_a === 1'b1);
      nb += int'(irq_b === 1'b1);
      @(negedge clk_sys);
    end
  endtask

  function automatic logic hit(input logic [7:0] c, input logic [2:0] v);
    return (v[2] & c[4]) | (v[1] & c[2]) | (v[0] & c[1]);
  endfunction

  function automatic logic [7:0] en_bit(input int j);
    return (j == 0) ? 8'h02 : ((j == 1) ? 8'h04 : 8'h10);
  endfunction

  function automatic logic exp_o(input int c, input logic [5:0] s);
    case (c)
      3: return s[5];
      4: return s[3];
      8: return s[2];
      9: return s[1];
      10: return s[0];
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    conclude();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] d, ca, cb;
    logic [5:0] s;
    logic [2:0] v;
    logic drv;
    int na, nb;
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    evt = '0;
    ext_en = 1'b0;
    ext_val = 1'b0;
    {div_clk, bclk, wclk, mod_clk} = 4'h0;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    // reserved slot is only ever read here, never written
    for (int i = 0; i < 5; i++) begin
      rd((i == 4) ? 8'h40 : 8'h30 + 8'(i), d);
      chk(d & 8'hfd, 8'h00);
    end
    // source gating, corner cases then random mixes
    for (int k = 0; k < 16; k++) begin
      v = (k < 3) ? 3'(1 << (k % 3)) : 3'(7 ^ (1 << (k % 3)));
      ca = (k < 3) ? en_bit(k % 3) : 8'h00;
      cb = (k < 3) ? 8'h00 : en_bit(k % 3);
      if (k >= 6) begin
        // reserved bits kept at zero
        ca = 8'($random(seed)) & 8'h16;
        cb = 8'($random(seed)) & 8'h16;
        v = 3'($random(seed));
      end
      wr(IPSEL_OFS_IRQ_A, ca);
      wr(IPSEL_OFS_IRQ_B, cb);
      rd(IPSEL_OFS_IRQ_B, d);
      chk(d, cb);
      fire(v);
      count(2 * PER, na, nb);
      chk(8'(na), hit(ca, v) ? 8'(PUL) : 8'h00);
      chk(8'(nb), hit(cb, v) ? 8'(PUL) : 8'h00);
      chk(8'(evt_pending), 8'(v));
      rd(k[0] ? IPSEL_OFS_FLAG_ADC : IPSEL_OFS_FLAG_OVF, d);
      chk(8'(evt_pending), 8'h00);
    end
    // repeated trains on both outputs, stopped by a flag read
    wr(IPSEL_OFS_IRQ_A, 8'h03);
    wr(IPSEL_OFS_IRQ_B, 8'h11);
    fire(3'b101);
    count(3 * PER - 2, na, nb);
    chk(8'(na), 8'(3 * PUL));
    chk(8'(nb), 8'(3 * PUL));
    rd(IPSEL_OFS_FLAG_ADC, d);
    count(2 * PER, na, nb);
    chk(8'(na + nb), 8'h00);
    // fresh trigger in mid pulse restarts it
    wr(IPSEL_OFS_IRQ_A, 8'h02);
    fire(3'b001);
    count(2, na, nb);
    fire(3'b001);
    count(PER, na, nb);
    chk(8'(na), 8'(PUL));
    // pin functions; code 7 is never programmed
    for (int c = 0; c < 11; c++) begin
      if (c == 7) continue;
      s = 6'($random(seed));
      {div_clk, bclk, wclk, mod_clk} <= s[3:0];
      ext_en <= (c == 1 || c == 2);
      ext_val <= s[4];
      drv = (c >= 3);
      wr(IPSEL_OFS_PIN, {2'b00, 4'(c), 1'b0, s[5]});
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(8'(pin_oe_n), 8'(!drv));
      chk(8'(pin_ie), 8'(c == 1 || c == 2));
      if (drv)
        chk(8'(pin_o), 8'(exp_o(c, s)));
      chk(8'(sec_pin_in), 8'((c == 1) & s[4]));
      chk(8'(general_input), 8'((c == 2) & s[4]));
      rd(IPSEL_OFS_PIN, d);
      chk(d & ((c == 0) ? 8'hfd : 8'hff), {2'b00, 4'(c), drv ? exp_o(c, s) : s[4] & (c != 0), s[5]});
    end
    conclude();
  end
endmodule

// file: logic/ipsel_pkg.sv
// package: register map, field layouts, timing constants and types of the interrupt pulse / pin select block
package ipsel_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] IPSEL_OFS_FLAG_OVF  = 8'h2a;
  localparam logic [7:0] IPSEL_OFS_FLAG_ADC  = 8'h2d;
  localparam logic [7:0] IPSEL_OFS_IRQ_A     = 8'h30;
  localparam logic [7:0] IPSEL_OFS_IRQ_B     = 8'h31;
  localparam logic [7:0] IPSEL_OFS_RSVD      = 8'h32;
  localparam logic [7:0] IPSEL_OFS_PIN       = 8'h33;

  // ==========================================================
  // reset values
  localparam logic [7:0] IPSEL_RST_IRQ_CTRL  = 8'h00;
  localparam logic [7:0] IPSEL_RST_PIN_CTRL  = 8'h00;

  // ==========================================================
  // pin function codes
  localparam logic [3:0] IPSEL_FN_OFF        = 4'h0;
  localparam logic [3:0] IPSEL_FN_IN         = 4'h1;
  localparam logic [3:0] IPSEL_FN_GPI        = 4'h2;
  localparam logic [3:0] IPSEL_FN_GPO        = 4'h3;
  localparam logic [3:0] IPSEL_FN_CLKDIV     = 4'h4;
  localparam logic [3:0] IPSEL_FN_IRQ_A      = 4'h5;
  localparam logic [3:0] IPSEL_FN_IRQ_B      = 4'h6;
  localparam logic [3:0] IPSEL_FN_SEC_BCLK   = 4'h8;
  localparam logic [3:0] IPSEL_FN_SEC_WCLK   = 4'h9;
  localparam logic [3:0] IPSEL_FN_MOD_CLK    = 4'ha;

  // ==========================================================
  // timing
  localparam int IPSEL_CLK_MHZ        = 250;
  localparam int IPSEL_PULSE_US       = 2000;
  localparam int IPSEL_PERIOD_US      = 4000;
  localparam int IPSEL_PULSE_CYC_DEF  = IPSEL_PULSE_US * IPSEL_CLK_MHZ;
  localparam int IPSEL_PERIOD_CYC_DEF = IPSEL_PERIOD_US * IPSEL_CLK_MHZ;
  localparam int IPSEL_CNT_W          = 20;

  // ==========================================================
  // types
  typedef struct packed {
    logic [2:0] rsvd_hi;
    logic       agc_en;
    logic       rsvd_lo;
    logic       eng_en;
    logic       data_en;
    logic       repeat_en;
  } ipsel_irq_ctrl_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [3:0] func;
    logic       in_val;
    logic       out_val;
  } ipsel_pin_ctrl_t;

  typedef struct packed {
    logic agc;
    logic eng;
    logic data;
  } ipsel_evt_t;

  typedef enum logic [1:0] {
    IPSEL_IDLE,
    IPSEL_HIGH,
    IPSEL_LOW
  } ipsel_pulse_st_t;

endpackage

// file: logic/ipsel_top.sv
// design: two interrupt pulse generators and the microphone clock pin function select
//
// Operation
// - agc noise source gated by D4
// - engine and overflow sources gated by D2
// - data-available source gated by D1
// - D0 low gives one 2 ms pulse
// - D0 high repeats pulses until flag read
// - second output has identical own control
// - code 0000 powers down both pin buffers
// - code 0001 makes pin the secondary input (sec_pin_in)
// - code 0010 makes pin a general-purpose input
// - D1 returns sampled pin input level
// - code 0011 drives D0 onto pin
// - code 0100 drives divided clock out
// - codes 0101/0110 drive interrupt outputs a/b
// - codes 1000/1001 drive secondary bit/word clocks
// - code 1010 drives modulator clock out
// - sticky flags clear on read, set anew
`timescale 1ns/100ps

module ipsel_top
  import ipsel_pkg::*;
#(
  parameter int PULSE_CYC  = IPSEL_PULSE_CYC_DEF,
  parameter int PERIOD_CYC = IPSEL_PERIOD_CYC_DEF
) (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire ipsel_evt_t evt,
  output ipsel_evt_t      evt_pending,
  input  wire logic       divided_clock_out,
  input  wire logic       sec_bclk_out,
  input  wire logic       sec_wclk_out,
  input  wire logic       modulator_clock,
  input  wire logic       mic_clock_pin_i,
  output logic            mic_clock_pin_o,
  output logic            mic_clock_pin_oe_n,
  output logic            mic_clock_pin_ie,
  output logic            irq_out_a,
  output logic            irq_out_b,
  output logic            sec_pin_in,
  output logic            general_input
);

  localparam logic [IPSEL_CNT_W-1:0] PULSE_LAST  = IPSEL_CNT_W'(PULSE_CYC - 1);
  localparam logic [IPSEL_CNT_W-1:0] PERIOD_LAST = IPSEL_CNT_W'(PERIOD_CYC - 1);

  // ==========================================================
  // helpers
  function automatic logic grp_hit(input ipsel_irq_ctrl_t c, input ipsel_evt_t e);
    grp_hit = (c.agc_en & e.agc) | (c.eng_en & e.eng) | (c.data_en & e.data);
  endfunction

  function automatic logic [7:0] irq_ctrl_wr(input logic [7:0] w);
    ipsel_irq_ctrl_t c;
    c           = ipsel_irq_ctrl_t'(w);
    c.rsvd_hi   = 3'h0;
    c.rsvd_lo   = 1'b0;
    irq_ctrl_wr = 8'(c);
  endfunction

  // ==========================================================
  // register port decode
  ipsel_irq_ctrl_t ctrl_q [2];
  ipsel_pin_ctrl_t pin_q;
  logic            level_q;
  logic [7:0]      rdata_d;

  wire logic wr_a     = reg_wr && (reg_addr == IPSEL_OFS_IRQ_A);
  wire logic wr_b     = reg_wr && (reg_addr == IPSEL_OFS_IRQ_B);
  wire logic wr_pin   = reg_wr && (reg_addr == IPSEL_OFS_PIN);
  wire logic flag_rd  = reg_rd && ((reg_addr == IPSEL_OFS_FLAG_OVF) || (reg_addr == IPSEL_OFS_FLAG_ADC));

  wire logic [7:0] pin_rd = {2'b00, pin_q.func, level_q, pin_q.out_val};

  // reserved slot and unmapped offsets read as zero; their writes are dropped
  assign rdata_d = (reg_addr == IPSEL_OFS_IRQ_A) ? 8'(ctrl_q[0]) :
                   (reg_addr == IPSEL_OFS_IRQ_B) ? 8'(ctrl_q[1]) :
                   (reg_addr == IPSEL_OFS_PIN)   ? pin_rd : 8'h00;

  // ==========================================================
  // control registers
  // independent control per output
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_q[0] <= ipsel_irq_ctrl_t'(IPSEL_RST_IRQ_CTRL);
      ctrl_q[1] <= ipsel_irq_ctrl_t'(IPSEL_RST_IRQ_CTRL);
      pin_q     <= ipsel_pin_ctrl_t'(IPSEL_RST_PIN_CTRL);
      reg_rdata <= 8'h00;
    end else begin
      if (wr_a) begin
        ctrl_q[0] <= ipsel_irq_ctrl_t'(irq_ctrl_wr(reg_wdata));
      end
      if (wr_b) begin
        ctrl_q[1] <= ipsel_irq_ctrl_t'(irq_ctrl_wr(reg_wdata));
      end
      // reserved and read-only bits are not stored, so a stray write cannot stick
      if (wr_pin) begin
        pin_q <= ipsel_pin_ctrl_t'({2'b00, reg_wdata[5:2], 1'b0, reg_wdata[0]});
      end
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // ==========================================================
  // sticky event record
  ipsel_evt_t pend_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pend_q <= '0;
    end else if (flag_rd) begin
      pend_q <= evt;
    end else begin
      pend_q <= pend_q | evt;
    end
  end

  assign evt_pending = pend_q;

  // ==========================================================
  // pulse generators
  ipsel_pulse_st_t         st_q  [2];
  logic [IPSEL_CNT_W-1:0]  cnt_q [2];
  logic [1:0]              trig;
  logic [1:0]              irq;

  for (genvar i = 0; i < 2; i++) begin : g_pulse
    wire logic             rep    = ctrl_q[i].repeat_en;
    wire logic             stop   = flag_rd && rep;
    wire logic [IPSEL_CNT_W-1:0] cnt_inc = cnt_q[i] + IPSEL_CNT_W'(1);

    assign trig[i] = grp_hit(ctrl_q[i], evt);
    assign irq[i]  = (st_q[i] == IPSEL_HIGH);

    always_ff @(posedge clk_sys) begin
      if (srst) begin
        st_q[i]  <= IPSEL_IDLE;
        cnt_q[i] <= '0;
      end else if (trig[i]) begin
        st_q[i]  <= IPSEL_HIGH;
        cnt_q[i] <= '0;
      end else begin
        unique case (st_q[i])
          IPSEL_IDLE: begin
            cnt_q[i] <= '0;
          end
          IPSEL_HIGH: begin
            if (stop) begin
              st_q[i]  <= IPSEL_IDLE;
              cnt_q[i] <= '0;
            end else begin
              if (cnt_q[i] == PULSE_LAST) begin
                st_q[i] <= IPSEL_LOW;
              end
              cnt_q[i] <= cnt_inc;
            end
          end
          IPSEL_LOW: begin
            if (stop) begin
              st_q[i]  <= IPSEL_IDLE;
              cnt_q[i] <= '0;
            end else if (cnt_q[i] == PERIOD_LAST) begin
              st_q[i]  <= rep ? IPSEL_HIGH : IPSEL_IDLE;
              cnt_q[i] <= '0;
            end else begin
              cnt_q[i] <= cnt_inc;
            end
          end
        endcase
      end
    end

    // rise only from a trigger or a repeat
    irq_rise_cause_a: assert property (@(posedge clk_sys) disable iff (srst)
      $rose(irq[i]) |-> $past(trig[i]) || ($past(st_q[i]) == IPSEL_LOW && $past(rep)))
      else $error("interrupt rose without cause");

    agc_mask_a: assert property (@(posedge clk_sys) disable iff (srst)
      (st_q[i] == IPSEL_IDLE && !ctrl_q[i].agc_en && evt == 3'b100) |=> st_q[i] == IPSEL_IDLE)
      else $error("masked agc event started a pulse");

    eng_mask_a: assert property (@(posedge clk_sys) disable iff (srst)
      (st_q[i] == IPSEL_IDLE && !ctrl_q[i].eng_en && evt == 3'b010) |=> st_q[i] == IPSEL_IDLE)
      else $error("masked engine event started a pulse");

    data_start_a: assert property (@(posedge clk_sys) disable iff (srst)
      (ctrl_q[i].data_en && evt.data) |=> irq[i] && cnt_q[i] == '0)
      else $error("enabled data event did not start a pulse");

    pulse_width_a: assert property (@(posedge clk_sys) disable iff (srst)
      $fell(irq[i]) && !$past(stop) |-> $past(cnt_q[i]) == PULSE_LAST)
      else $error("pulse width wrong");

    train_repeat_a: assert property (@(posedge clk_sys) disable iff (srst)
      (st_q[i] == IPSEL_LOW && cnt_q[i] == PERIOD_LAST && rep && !flag_rd) |=> irq[i] ##1 irq[i])
      else $error("repeat pulse missing");

    train_stop_a: assert property (@(posedge clk_sys) disable iff (srst)
      (stop && !trig[i] && st_q[i] != IPSEL_IDLE) |=> st_q[i] == IPSEL_IDLE [*2])
      else $error("flag read did not end train");

    single_end_a: assert property (@(posedge clk_sys) disable iff (srst)
      (st_q[i] == IPSEL_LOW && cnt_q[i] == PERIOD_LAST && !rep && !trig[i]) |=> st_q[i] == IPSEL_IDLE)
      else $error("single pulse repeated");
  end

  assign irq_out_a = irq[0];
  assign irq_out_b = irq[1];

  // ==========================================================
  // pin input sampling
  logic [2:0] sync_q;

  // level changes only once the last two stages agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync_q  <= 3'h0;
      level_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], mic_clock_pin_i};
      if (sync_q[2] == sync_q[1]) begin
        level_q <= sync_q[2];
      end
    end
  end

  // ==========================================================
  // pin function select
  wire logic [3:0] fn = pin_q.func;

  // input buffer powered only for input codes
  wire logic ie_d = (fn == IPSEL_FN_IN) || (fn == IPSEL_FN_GPI);

  wire logic drive_d = (fn == IPSEL_FN_GPO) || (fn == IPSEL_FN_CLKDIV) || (fn == IPSEL_FN_IRQ_A)
                       || (fn == IPSEL_FN_IRQ_B) || (fn == IPSEL_FN_SEC_BCLK)
                       || (fn == IPSEL_FN_SEC_WCLK) || (fn == IPSEL_FN_MOD_CLK);

  wire logic out_d = (fn == IPSEL_FN_GPO)      ? pin_q.out_val     :
                     (fn == IPSEL_FN_CLKDIV)   ? divided_clock_out :
                     (fn == IPSEL_FN_IRQ_A)    ? irq[0]            :
                     (fn == IPSEL_FN_IRQ_B)    ? irq[1]            :
                     (fn == IPSEL_FN_SEC_BCLK) ? sec_bclk_out      :
                     (fn == IPSEL_FN_SEC_WCLK) ? sec_wclk_out      :
                     (fn == IPSEL_FN_MOD_CLK)  ? modulator_clock   : 1'b0;

  // registered pin: clocks forwarded this way are resampled at 250 MHz
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mic_clock_pin_o    <= 1'b0;
      mic_clock_pin_oe_n <= 1'b1;
      mic_clock_pin_ie   <= 1'b0;
      sec_pin_in         <= 1'b0;
      general_input      <= 1'b0;
    end else begin
      mic_clock_pin_o    <= drive_d ? out_d : 1'b0;
      mic_clock_pin_oe_n <= !drive_d;
      mic_clock_pin_ie   <= ie_d;
      sec_pin_in         <= (fn == IPSEL_FN_IN) && level_q;
      general_input      <= (fn == IPSEL_FN_GPI) && level_q;
    end
  end

  pin_off_a: assert property (@(posedge clk_sys) disable iff (srst)
    (fn == IPSEL_FN_OFF && $past(fn) == IPSEL_FN_OFF) |=> mic_clock_pin_oe_n && !mic_clock_pin_ie)
    else $error("disabled pin still has a buffer on");

  gpo_level_a: assert property (@(posedge clk_sys) disable iff (srst)
    (fn == IPSEL_FN_GPO) |=> !mic_clock_pin_oe_n && mic_clock_pin_o == $past(pin_q.out_val))
    else $error("gpo level wrong");

  pin_irq_a: assert property (@(posedge clk_sys) disable iff (srst)
    (fn == IPSEL_FN_IRQ_A) |=> mic_clock_pin_o == $past(irq[0]))
    else $error("pin does not carry interrupt a");

  level_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    (reg_rd && reg_addr == IPSEL_OFS_PIN) |=> reg_rdata[1] == $past(level_q))
    else $error("pin level readback wrong");

  sticky_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
    (flag_rd && evt == 3'b000) |=> evt_pending == 3'b000)
    else $error("sticky flags not cleared by read");

endmodule
